// file: axis_homing_and_supervision.sv
// Homing sequencer, deviation supervision and register slave for one axis
//
// Our own choice: register access over AXI4-Lite.
module axis_homing_and_supervision
    import axis_homing_pkg::*;
#(
    parameter int PD_TICK = PD_TICK_CYC
) (
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    // AXI4-Lite write address, data and response
    input  wire logic [11:0]       i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    // AXI4-Lite read
    input  wire logic [11:0]       i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    // Switch pins
    input  wire switches_s         i_switches,
    // Motion core and driver
    input  wire logic signed [31:0] i_actual_pos,
    input  wire logic signed [31:0] i_encoder_pos,
    input  wire logic              i_standstill,
    input  wire logic              i_stall,
    input  wire logic [9:0]        i_load,
    input  wire logic [7:0]        i_drv_faults,
    input  wire logic              i_motion_cmd,
    output motion_cmd_s            o_motion,
    output logic                   o_stop,
    output logic                   o_standby,
    output logic [1:0]             o_coil_mode,
    output logic                   o_unit_pps,
    output logic                   o_shaft_load,
    output logic [31:0]            o_shaft_wdata
);

    typedef enum logic [2:0] {
        H_IDLE, H_SEEK_FAR, H_SEEK, H_BACK, H_FINE, H_ZERO
    } home_state_e;

    // Pin synchronisers
    switches_s sw_meta_reg, sw_reg;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sw_meta_reg <= '0;
            sw_reg      <= '0;
        end else begin
            sw_meta_reg <= i_switches;
            sw_reg      <= sw_meta_reg;
        end
    end

    // Register storage
    logic [31:0] pwm_amp_reg, mode_reg, coarse_reg, fine_reg, quad_reg, steps_reg;
    logic [31:0] counts_reg, dev_limit_reg, pd_delay_reg;
    logic [1:0]  coil_reg;
    logic        unit_reg;
    logic [31:0] span_reg, pre_pos_reg;
    logic [1:0]  flt_reg;

    // Write channel
    logic        aw_hold_reg, w_hold_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;
    logic        wr_ok;
    logic [9:0]  wr_idx;
    assign wr_fire = aw_hold_reg && w_hold_reg && !o_bvalid;
    assign wr_idx  = awaddr_reg[11:2];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            o_awready   <= 1'b1;
            o_wready    <= 1'b1;
            o_bvalid    <= 1'b0;
            o_bresp     <= RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= i_awaddr;
                o_awready   <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= i_wdata;
                wstrb_reg  <= i_wstrb;
                o_wready   <= 1'b0;
            end
            if (wr_fire) begin
                o_bvalid    <= 1'b1;
                o_bresp     <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // Write decode
    always_comb begin
        case (wr_idx)
            ADDR_PWM_AMP[9:0], ADDR_HOME_MODE[9:0], ADDR_COARSE_SPD[9:0],
            ADDR_FINE_SPD[9:0], ADDR_QUAD_CFG[9:0], ADDR_STEPS_REV[9:0],
            ADDR_COIL_OPT[9:0], ADDR_SHAFT_CNT[9:0], ADDR_COUNTS_REV[9:0],
            ADDR_DEV_LIMIT[9:0], ADDR_PD_DELAY[9:0], ADDR_UNIT_SEL[9:0],
            ADDR_CONTROL[9:0]: wr_ok = (awaddr_reg[1:0] == 2'b00);
            default: wr_ok = 1'b0;
        endcase
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    logic wr_go;
    assign wr_go = wr_fire && wr_ok;
    logic home_cmd, stop_cmd;
    assign home_cmd = wr_go && wr_idx == ADDR_CONTROL[9:0] && wstrb_reg[0] && wdata_reg[CTL_HOME_BIT];
    assign stop_cmd = wr_go && wr_idx == ADDR_CONTROL[9:0] && wstrb_reg[0] && wdata_reg[CTL_STOP_BIT];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwm_amp_reg   <= '0;
            mode_reg      <= HOME_MODE_RST;
            coarse_reg    <= '0;
            fine_reg      <= '0;
            quad_reg      <= '0;
            steps_reg     <= STEPS_REV_RST;
            counts_reg    <= '0;
            dev_limit_reg <= '0;
            pd_delay_reg  <= PD_DELAY_RST;
            coil_reg      <= 2'b00;
            unit_reg      <= UNIT_SEL_RST[0];
        end else if (wr_go) begin
            case (wr_idx)
                ADDR_PWM_AMP[9:0]:    pwm_amp_reg   <= merge(pwm_amp_reg, wdata_reg, wstrb_reg);
                ADDR_HOME_MODE[9:0]:  mode_reg      <= merge(mode_reg, wdata_reg, wstrb_reg);
                ADDR_COARSE_SPD[9:0]: coarse_reg    <= merge(coarse_reg, wdata_reg, wstrb_reg);
                ADDR_FINE_SPD[9:0]:   fine_reg      <= merge(fine_reg, wdata_reg, wstrb_reg);
                ADDR_QUAD_CFG[9:0]:   quad_reg      <= merge(quad_reg, wdata_reg, wstrb_reg);
                ADDR_STEPS_REV[9:0]:  steps_reg     <= merge(steps_reg, wdata_reg, wstrb_reg);
                ADDR_COUNTS_REV[9:0]: counts_reg    <= merge(counts_reg, wdata_reg, wstrb_reg);
                ADDR_DEV_LIMIT[9:0]:  dev_limit_reg <= merge(dev_limit_reg, wdata_reg, wstrb_reg);
                ADDR_PD_DELAY[9:0]:   pd_delay_reg  <= merge(pd_delay_reg, wdata_reg, wstrb_reg);
                ADDR_COIL_OPT[9:0]:   if (wstrb_reg[0]) coil_reg <= wdata_reg[1:0];
                ADDR_UNIT_SEL[9:0]:   if (wstrb_reg[0]) unit_reg <= wdata_reg[0];
                default: ;
            endcase
        end
    end

    // Encoder counter load goes to the counter owner
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_shaft_load  <= 1'b0;
            o_shaft_wdata <= '0;
        end else begin
            o_shaft_load  <= wr_go && wr_idx == ADDR_SHAFT_CNT[9:0];
            o_shaft_wdata <= merge(i_encoder_pos, wdata_reg, wstrb_reg);
        end
    end

    // Homing sequencer
    home_state_e st_reg;
    logic        two_sided_reg, far_first_reg, span_meas_reg, ignore_end_reg, back_seen_reg;
    logic        home_lvl, ref_sw, far_sw, rev_sw;
    logic [3:0]  mode_base;
    logic        homing;
    logic        dev_trip;
    assign mode_base = mode_reg[3:0];
    assign home_lvl  = sw_reg.home ^ mode_reg[MODE_INV_BIT];
    assign ref_sw    = mode_reg[MODE_RIGHT_BIT] ? sw_reg.right : sw_reg.left;
    assign far_sw    = mode_reg[MODE_RIGHT_BIT] ? sw_reg.left : sw_reg.right;
    assign rev_sw    = (mode_base == 4'd5) ? sw_reg.left : sw_reg.right;
    assign homing    = (st_reg != H_IDLE);

    logic dir_neg_reg;
    logic [31:0] speed_reg;
    logic        clear_reg;
    logic signed [31:0] far_pos_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg         <= H_IDLE;
            two_sided_reg  <= 1'b0;
            far_first_reg  <= 1'b0;
            span_meas_reg  <= 1'b0;
            ignore_end_reg <= 1'b0;
            back_seen_reg  <= 1'b0;
            dir_neg_reg    <= 1'b0;
            speed_reg      <= '0;
            clear_reg      <= 1'b0;
            far_pos_reg    <= '0;
            span_reg       <= '0;
            pre_pos_reg    <= '0;
        end else begin
            clear_reg <= 1'b0;
            if (o_motion.clear_pos) begin
                pre_pos_reg <= i_actual_pos;
            end
            if (stop_cmd || dev_trip) begin
                st_reg <= H_IDLE;
            end else begin
                case (st_reg)
                    H_IDLE: if (home_cmd) begin
                        speed_reg      <= coarse_reg;
                        two_sided_reg  <= mode_base == 4'd3 || mode_base == 4'd4;
                        far_first_reg  <= mode_base == 4'd2 || mode_base == 4'd3;
                        span_meas_reg  <= mode_base == 4'd2 || mode_base == 4'd3;
                        ignore_end_reg <= mode_base == 4'd7 || mode_base == 4'd8;
                        back_seen_reg  <= 1'b0;
                        if (mode_base == 4'd2 || mode_base == 4'd3) begin
                            st_reg      <= H_SEEK_FAR;
                            dir_neg_reg <= mode_reg[MODE_RIGHT_BIT];
                        end else if (mode_base >= 4'd1 && mode_base <= 4'd4) begin
                            st_reg      <= H_SEEK;
                            dir_neg_reg <= !mode_reg[MODE_RIGHT_BIT];
                        end else if (mode_base >= 4'd5 && mode_base <= 4'd8) begin
                            st_reg      <= H_SEEK;
                            dir_neg_reg <= mode_base == 4'd5 || mode_base == 4'd8;
                        end
                    end
                    H_SEEK_FAR: if (far_sw) begin
                        far_pos_reg <= i_actual_pos;
                        dir_neg_reg <= !dir_neg_reg;
                        st_reg      <= H_SEEK;
                    end
                    H_SEEK: begin
                        if (mode_base >= 4'd5) begin
                            if (!ignore_end_reg && !back_seen_reg && rev_sw) begin
                                dir_neg_reg   <= !dir_neg_reg;
                                back_seen_reg <= 1'b1;
                            end else if (home_lvl) begin
                                st_reg    <= H_FINE;
                                speed_reg <= fine_reg;
                                dir_neg_reg <= !dir_neg_reg;
                            end
                        end else if (ref_sw) begin
                            dir_neg_reg <= !dir_neg_reg;
                            speed_reg   <= fine_reg;
                            st_reg      <= two_sided_reg ? H_BACK : H_FINE;
                        end
                    end
                    H_BACK: if (!ref_sw) begin
                        dir_neg_reg <= !dir_neg_reg;
                        st_reg      <= H_FINE;
                    end
                    H_FINE: if ((mode_base >= 4'd5) ? !home_lvl : (two_sided_reg ? ref_sw : !ref_sw)) begin
                        st_reg <= H_ZERO;
                    end
                    H_ZERO: begin
                        clear_reg   <= 1'b1;
                        if (span_meas_reg) begin
                            span_reg <= far_pos_reg - i_actual_pos;
                        end
                        st_reg <= H_IDLE;
                    end
                    default: st_reg <= H_IDLE;
                endcase
            end
        end
    end

    // Deviation supervision
    logic signed [32:0] diff;
    logic [32:0] adiff;
    assign diff  = {i_actual_pos[31], i_actual_pos} - {i_encoder_pos[31], i_encoder_pos};
    assign adiff = diff[32] ? 33'(-diff) : 33'(diff);
    assign dev_trip = (dev_limit_reg[15:0] != 16'h0000)
                      && (adiff > {17'h00000, dev_limit_reg[15:0]});

    // Read handshake and faults
    logic rd_clear;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flt_reg <= 2'b00;
        end else begin
            if (rd_clear || i_motion_cmd || home_cmd) flt_reg <= 2'b00;
            if (i_stall) flt_reg[FLT_STALL_BIT] <= 1'b1;
            if (dev_trip) flt_reg[FLT_DEV_BIT] <= 1'b1;
        end
    end

    logic [31:0] rd_mux;
    logic [9:0]  rd_idx;
    logic        rd_ok;
    assign rd_idx = i_araddr[11:2];
    always_comb begin
        rd_ok  = (i_araddr[1:0] == 2'b00);
        case (rd_idx)
            ADDR_PWM_AMP[9:0]:    rd_mux = pwm_amp_reg;
            ADDR_HOME_MODE[9:0]:  rd_mux = mode_reg;
            ADDR_COARSE_SPD[9:0]: rd_mux = coarse_reg;
            ADDR_FINE_SPD[9:0]:   rd_mux = fine_reg;
            ADDR_SPAN[9:0]:       rd_mux = span_reg;
            ADDR_PRE_POS[9:0]:    rd_mux = pre_pos_reg;
            ADDR_QUAD_CFG[9:0]:   rd_mux = quad_reg;
            ADDR_STEPS_REV[9:0]:  rd_mux = steps_reg;
            ADDR_COIL_OPT[9:0]:   rd_mux = {30'h0, coil_reg};
            ADDR_LOAD[9:0]:       rd_mux = {22'h0, i_load};
            ADDR_FAULTS[9:0]:     rd_mux = {30'h0, flt_reg};
            ADDR_DRV_FAULTS[9:0]: rd_mux = {24'h0, i_drv_faults};
            ADDR_SHAFT_CNT[9:0]:  rd_mux = i_encoder_pos;
            ADDR_COUNTS_REV[9:0]: rd_mux = counts_reg;
            ADDR_DEV_LIMIT[9:0]:  rd_mux = dev_limit_reg;
            ADDR_PD_DELAY[9:0]:   rd_mux = pd_delay_reg;
            ADDR_UNIT_SEL[9:0]:   rd_mux = {31'h0, unit_reg};
            ADDR_CONTROL[9:0]:    rd_mux = 32'h0000_0000;
            ADDR_STATUS[9:0]:     rd_mux = {29'h0, o_standby, o_stop, homing};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok  = 1'b0;
            end
        endcase
    end
    assign rd_clear = i_arvalid && o_arready && rd_ok && rd_idx == ADDR_FAULTS[9:0];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_mux;
            o_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // Standstill power-down timer
    logic [31:0] tick_cnt_reg;
    logic [31:0] pd_cnt_reg;
    logic        standby_next;
    // Next standby level, so the coil option drops with standby
    assign standby_next = i_standstill && !homing
                          && (o_standby || pd_cnt_reg >= pd_delay_reg);
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_reg <= '0;
            pd_cnt_reg   <= '0;
            o_standby    <= 1'b0;
        end else if (!i_standstill || homing) begin
            tick_cnt_reg <= '0;
            pd_cnt_reg   <= '0;
            o_standby    <= 1'b0;
        end else if (pd_cnt_reg >= pd_delay_reg) begin
            o_standby <= 1'b1;
        end else if (tick_cnt_reg == 32'(PD_TICK - 1)) begin
            tick_cnt_reg <= '0;
            pd_cnt_reg   <= pd_cnt_reg + 32'd1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'd1;
        end
    end

    // Outputs to motion core
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_motion    <= '0;
            o_stop      <= 1'b0;
            o_coil_mode <= 2'b00;
            o_unit_pps  <= UNIT_SEL_RST[0];
        end else begin
            o_motion.run       <= homing && !dev_trip;
            o_motion.dir_neg   <= dir_neg_reg;
            o_motion.speed     <= speed_reg;
            o_motion.clear_pos <= clear_reg;
            o_stop             <= dev_trip || stop_cmd;
            o_coil_mode        <= standby_next ? coil_reg : 2'b00;
            o_unit_pps         <= unit_reg;
        end
    end

endmodule // axis_homing_and_supervision

// file: axis_homing_and_supervision_bench.sv
// Register-level tests of the axis homing block
module axis_homing_and_supervision_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import axis_homing_pkg::*;
    logic i_core_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_stop, o_standby;
    logic i_standstill, i_stall, i_motion_cmd, o_unit_pps, o_shaft_load;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, o_shaft_wdata, d;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, o_coil_mode, resp;
    logic [9:0] i_load;
    logic [7:0] i_drv_faults, dev;
    logic signed [31:0] i_actual_pos, i_encoder_pos, last;
    switches_s i_switches;
    motion_cmd_s o_motion;
    int mismatches, checked, n;
    logic [7:0] modes [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h41};
    logic [8:0] neg = 9'b0_1001_1001;
    axis_homing_and_supervision #(.PD_TICK(10)) dut_u (.*);
    axis_partner pm_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_motion(o_motion),
        .i_dev(dev), .o_pos(i_actual_pos), .o_enc(i_encoder_pos), .o_last(last),
        .o_sw(i_switches), .o_still(i_standstill));
    initial begin
        i_core_clk = 0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic hang(input int k);
        if (k >= 99) begin
            chk(0, 1, "timeout");
            wrap_up;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int k;
        k = 0;
        i_awaddr <= a << BYTE_SHIFT;
        i_wdata <= v;
        i_awvalid <= 1;
        i_wvalid <= 1;
        do begin
            @(posedge i_core_clk);
            if (o_awready) i_awvalid <= 0;
            if (o_wready) i_wvalid <= 0;
        end while (!o_bvalid && ++k < 99);
        resp = o_bresp;
        hang(k);
    endtask
    task automatic rd(input logic [11:0] a);
        int k;
        k = 0;
        i_araddr <= a << BYTE_SHIFT;
        i_arvalid <= 1;
        do begin
            @(posedge i_core_clk);
            if (o_arready) i_arvalid <= 0;
        end while (!o_rvalid && ++k < 99);
        d = o_rdata;
        resp = o_rresp;
        hang(k);
    endtask
    initial begin
        {i_awvalid, i_wvalid, i_arvalid, i_stall, i_motion_cmd, i_rst_n} = '0;
        {i_bready, i_rready, i_wstrb, i_load, i_drv_faults} = {6'h3F, 10'h3FF, 8'h5A};
        {i_awaddr, i_araddr, i_wdata, dev} = '0;
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1;
        rd(ADDR_UNIT_SEL);
        chk(d, 32'h1, "unit reset");
        chk(o_unit_pps, 1'b1, "pps out");
        rd(ADDR_PD_DELAY);
        chk(d, 32'hC8, "delay reset");
        rd(ADDR_LOAD);
        chk(d, 32'h3FF, "load");
        rd(12'h000);
        chk(resp, RESP_SLVERR, "unmapped");
        wr(ADDR_UNIT_SEL, 32'h0);
        @(posedge i_core_clk);
        chk(o_unit_pps, 1'b0, "native");
        wr(ADDR_SHAFT_CNT, 32'h1234);
        chk(o_shaft_load, 1'b1, "encoder load pulse");
        chk(o_shaft_wdata, 32'h1234, "encoder load value");
        $display("T1 done");
        wr(ADDR_COARSE_SPD, 32'h64);
        wr(ADDR_FINE_SPD, 32'h10);
        wr(ADDR_PD_DELAY, 32'h3);
        wr(ADDR_COIL_OPT, 32'h2);
        for (int i = 0; i < 9; i++) begin
            wr(ADDR_HOME_MODE, 32'(modes[i]));
            wr(ADDR_CONTROL, 32'h1);
            repeat (4) @(posedge i_core_clk);
            chk(o_motion.dir_neg, neg[i], "direction");
            chk(o_motion.speed, 32'h64, "coarse speed");
            wr(ADDR_CONTROL, 32'h2);
        end
        repeat (15) @(posedge i_core_clk);
        chk(o_standby, 1'b0, "early standby");
        repeat (30) @(posedge i_core_clk);
        chk(o_standby, 1'b1, "standby");
        chk(o_coil_mode, 2'h2, "coil option");
        $display("T2 done");
        wr(ADDR_HOME_MODE, 32'h87);
        wr(ADDR_CONTROL, 32'h1);
        repeat (4) @(posedge i_core_clk);
        chk(o_motion.dir_neg, 1'b1, "inverted home found");
        chk(o_motion.speed, 32'h10, "fine speed");
        wr(ADDR_CONTROL, 32'h2);
        wr(ADDR_HOME_MODE, 32'h7);
        wr(ADDR_CONTROL, 32'h1);
        n = 0;
        while (!o_motion.clear_pos && n < 300) begin
            @(posedge i_core_clk);
            n++;
        end
        hang(n < 300 ? 0 : 99);
        repeat (3) @(posedge i_core_clk);
        rd(ADDR_PRE_POS);
        chk(d, last, "captured position");
        $display("T3 done");
        i_stall <= 1;
        @(posedge i_core_clk);
        i_stall <= 0;
        rd(ADDR_FAULTS);
        chk(d, 32'h1, "stall flag");
        rd(ADDR_FAULTS);
        chk(d, 32'h0, "read clears");
        i_stall <= 1;
        @(posedge i_core_clk);
        i_stall <= 0;
        i_motion_cmd <= 1;
        @(posedge i_core_clk);
        i_motion_cmd <= 0;
        rd(ADDR_FAULTS);
        chk(d, 32'h0, "command clears");
        dev <= 8'h6;
        wr(ADDR_DEV_LIMIT, 32'h5);
        rd(ADDR_FAULTS);
        chk(d, 32'h2, "deviation flag");
        chk(o_stop, 1'b1, "deviation stop");
        wr(ADDR_DEV_LIMIT, 32'h0);
        rd(ADDR_FAULTS);
        rd(ADDR_FAULTS);
        chk(d, 32'h0, "limit zero off");
        chk(o_stop, 1'b0, "no stop when off");
        $display("T4 done");
        wrap_up;
    end
endmodule // axis_homing_and_supervision_bench

// file: axis_homing_assertions.sv
// Port checks for the axis homing block
module axis_homing_assertions
    import axis_homing_pkg::*;
(
    input wire logic i_core_clk, i_rst_n, i_awvalid, i_wvalid, i_arvalid,
    input wire logic i_standstill, o_awready, o_wready, o_bvalid,
    input wire logic o_arready, o_rvalid, o_stop, o_standby,
    input wire logic [1:0] o_coil_mode,
    input wire motion_cmd_s o_motion
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
    property p_b; s_wr |-> ##2 o_bvalid; endproperty
    a_b: assert property (p_b) else $error("late write response");
    property p_bh; o_bvalid |-> !o_awready && !o_wready; endproperty
    a_bh: assert property (p_bh) else $error("write taken during response");
    property p_r; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_r: assert property (p_r) else $error("late read data");
    property p_coil; !o_standby |-> o_coil_mode == 2'h0; endproperty
    a_coil: assert property (p_coil) else $error("coil option outside standby");
    property p_sb; !i_standstill |-> ##[1:3] !o_standby; endproperty
    a_sb: assert property (p_sb) else $error("standby while moving");
    property p_pd; $rose(o_standby) |-> $past(i_standstill, 8); endproperty
    a_pd: assert property (p_pd) else $error("standby too early");
    property p_clr; $rose(o_motion.clear_pos) |=> !o_motion.clear_pos; endproperty
    a_clr: assert property (p_clr) else $error("clear not a pulse");
    property p_stop; o_stop |-> ##[0:2] !o_motion.run; endproperty
    a_stop: assert property (p_stop) else $error("motor not stopped");
endmodule // axis_homing_assertions

bind axis_homing_and_supervision axis_homing_assertions chk_u (.*);

// file: axis_homing_pkg.sv
// Constants and types for the axis homing and supervision block
package axis_homing_pkg;

    localparam logic [11:0] ADDR_PWM_AMP     = 12'h0BC;
    localparam logic [11:0] ADDR_HOME_MODE   = 12'h0C1;
    localparam logic [11:0] ADDR_COARSE_SPD  = 12'h0C2;
    localparam logic [11:0] ADDR_FINE_SPD    = 12'h0C3;
    localparam logic [11:0] ADDR_SPAN        = 12'h0C4;
    localparam logic [11:0] ADDR_PRE_POS     = 12'h0C5;
    localparam logic [11:0] ADDR_QUAD_CFG    = 12'h0C9;
    localparam logic [11:0] ADDR_STEPS_REV   = 12'h0CA;
    localparam logic [11:0] ADDR_COIL_OPT    = 12'h0CC;
    localparam logic [11:0] ADDR_LOAD        = 12'h0CE;
    localparam logic [11:0] ADDR_FAULTS      = 12'h0CF;
    localparam logic [11:0] ADDR_DRV_FAULTS  = 12'h0D0;
    localparam logic [11:0] ADDR_SHAFT_CNT   = 12'h0D1;
    localparam logic [11:0] ADDR_COUNTS_REV  = 12'h0D2;
    localparam logic [11:0] ADDR_DEV_LIMIT   = 12'h0D4;
    localparam logic [11:0] ADDR_PD_DELAY    = 12'h0D6;
    localparam logic [11:0] ADDR_UNIT_SEL    = 12'h0FF;
    localparam logic [11:0] ADDR_CONTROL     = 12'h100;
    localparam logic [11:0] ADDR_STATUS      = 12'h101;

    localparam int BYTE_SHIFT = 2;

    localparam logic [31:0] STEPS_REV_RST = 32'h0000_00C8;
    localparam logic [31:0] PD_DELAY_RST  = 32'h0000_00C8;
    localparam logic [31:0] UNIT_SEL_RST  = 32'h0000_0001;
    localparam logic [31:0] HOME_MODE_RST = 32'h0000_0001;

    localparam int MODE_INV_BIT   = 7;
    localparam int MODE_RIGHT_BIT = 6;
    localparam int FLT_STALL_BIT  = 0;
    localparam int FLT_DEV_BIT    = 1;
    localparam int CTL_HOME_BIT   = 0;
    localparam int CTL_STOP_BIT   = 1;

    localparam int  CLK_HZ        = 100_000_000;
    localparam int  PD_TICK_MS    = 10;
    localparam int  PD_TICK_CYC   = CLK_HZ / 1000 * PD_TICK_MS;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        COIL_NORMAL,
        COIL_FREEWHEEL,
        COIL_SHORT_LOW,
        COIL_SHORT_HIGH
    } coil_opt_e;

    typedef struct packed {
        logic        left;
        logic        right;
        logic        home;
    } switches_s;

    typedef struct packed {
        logic        run;
        logic        dir_neg;
        logic [31:0] speed;
        logic        clear_pos;
    } motion_cmd_s;

endpackage

// file: axis_partner.sv
// Behavioural axis: motor position, encoder and switches
module axis_partner
    import axis_homing_pkg::*;
(
    input  wire logic          i_core_clk, i_rst_n,
    input  wire motion_cmd_s   i_motion,
    input  wire logic [7:0]    i_dev,
    output logic signed [31:0] o_pos, o_enc, o_last,
    output switches_s          o_sw,
    output logic               o_still
);
    timeunit 1ns;
    timeprecision 1ns;
    assign o_enc = o_pos + 32'(i_dev);
    assign o_still = !i_motion.run;
    assign o_sw = '{o_pos < -100, o_pos > 100, o_pos > 40};
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pos <= '0;
            o_last <= '0;
        end else if (i_motion.clear_pos) begin
            o_last <= o_pos;
            o_pos <= '0;
        end else if (i_motion.run) begin
            o_pos <= i_motion.dir_neg ? o_pos - 1 : o_pos + 1;
        end
    end
endmodule // axis_partner
